// ---- asmi_defines.vh ----
// constants for the active stop mode interlock block
// Summary of operation
// - no entry or utility start across each other
// - overtravel drops the internal deceleration ramp
// - overtravel stop uses its configured method
// - after overtravel stop, hold time before release
// - servo-on withdrawal ends the mode at once
// - zero clamp off while active, analog variant
// - speed feedforward suppressed while active
// - torque feedforward suppressed while active
// - release needs safety on, hold, level
// - system reset ends mode, restarts servo
// - accepted recalculation ends mode, rejected keeps
`ifndef ASMI_DEFINES_VH
`define ASMI_DEFINES_VH

// bus and field widths
`define ASMI_ADDR_W 8
`define ASMI_DATA_W 32
`define ASMI_LVL_W 16
`define ASMI_HOLD_W 16
`define ASMI_CTRL_W 7
`define ASMI_STAT_W 8

// register offsets
`define ASMI_OFS_CTRL 8'h00
`define ASMI_OFS_HOLD 8'h04
`define ASMI_OFS_POSLVL 8'h08
`define ASMI_OFS_SPDLVL 8'h0c
`define ASMI_OFS_STATUS 8'h10
`define ASMI_OFS_UTIL 8'h14

// control register fields
`define ASMI_CTRL_POS_MODE 0
`define ASMI_CTRL_ANALOG 1
`define ASMI_CTRL_ZC 2
`define ASMI_CTRL_SFF 3
`define ASMI_CTRL_TFF 4
`define ASMI_CTRL_OT_LSB 5
`define ASMI_CTRL_OT_MSB 6

// status register fields
`define ASMI_STAT_ACTIVE 0
`define ASMI_STAT_DECEL 1
`define ASMI_STAT_OT 2
`define ASMI_STAT_HOLD_DONE 3
`define ASMI_STAT_UTIL 4
`define ASMI_STAT_ENTRY_REF 5
`define ASMI_STAT_UTIL_REF 6
`define ASMI_STAT_RELEASE_OK 7

// utility command fields
`define ASMI_UTIL_START 0
`define ASMI_UTIL_STOP 1

// reset values
`define ASMI_CTRL_RST 7'h1c
`define ASMI_HOLD_RST 16'h0064
`define ASMI_POSLVL_RST 16'h0100
`define ASMI_SPDLVL_RST 16'h0100

// timing: hold time is counted in ticks of one millisecond
`define ASMI_CLK_PERIOD_NS 25
`define ASMI_TICK_NS 1000000

// state codes
`define ASMI_ST_IDLE 2'h0
`define ASMI_ST_DECEL 2'h1
`define ASMI_ST_OTSTOP 2'h2

`endif

// ---- asmi_hold_timer.v ----
// hold-time counter: millisecond prescaler and tick counter
`timescale 1ns/1ps
`default_nettype none
`include "asmi_defines.vh"
module asmi_hold_timer #(
	parameter TICK_CYCLES = `ASMI_TICK_NS / `ASMI_CLK_PERIOD_NS
) (
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire clear,
	input wire [`ASMI_HOLD_W-1:0] hold_time,
	output wire elapsed
);
	reg [31:0] pre_reg;
	reg [`ASMI_HOLD_W-1:0] tick_reg;
	reg elapsed_reg;
	wire tick = (pre_reg == TICK_CYCLES - 1);

	// counter saturates so a long wait never wraps back below the hold time
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg <= 32'h00000000;
			tick_reg <= {`ASMI_HOLD_W{1'b0}};
			elapsed_reg <= 1'b0;
		end else if (ce) begin
			if (clear) begin
				pre_reg <= 32'h00000000;
				tick_reg <= {`ASMI_HOLD_W{1'b0}};
				elapsed_reg <= 1'b0;
			end else begin
				pre_reg <= tick ? 32'h00000000 : pre_reg + 32'h00000001;
				if (tick && (tick_reg != {`ASMI_HOLD_W{1'b1}}))
					tick_reg <= tick_reg + {{(`ASMI_HOLD_W-1){1'b0}}, 1'b1};
				elapsed_reg <= (tick_reg > hold_time); // strictly exceeded
			end
		end
	end
	assign elapsed = elapsed_reg;
endmodule // asmi_hold_timer
`default_nettype wire

// ---- asmi_host_model.sv ----
// host controller model: halts its reference while the mode is on
`timescale 1ns/1ps
`default_nettype none
module asmi_host_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic active_mode_on,
	input wire logic stubborn,
	input wire logic [15:0] ref_cmd,
	output logic [15:0] ref_abs
);
	// stubborn keeps the reference up, used only to hold release off
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ref_abs <= 16'h0000;
		else
			ref_abs <= (active_mode_on && !stubborn) ? 16'h0000 : ref_cmd;
	end
endmodule // asmi_host_model
`default_nettype wire

// ---- asmi_monitor.sv ----
// port assertions for the active stop mode interlock
`timescale 1ns/1ps
`default_nettype none
module asmi_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic servo_on_cmd,
	input wire logic system_reset_req,
	input wire logic recalc_start,
	input wire logic recalc_rejected,
	input wire logic active_mode_on,
	input wire logic internal_decel_en,
	input wire logic ot_stop_en,
	input wire logic speed_ff_en,
	input wire logic torque_ff_en,
	input wire logic utility_running,
	input wire logic servo_restart
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// four samples cover two sync flops and the state register
	sequence servo_dropped;
		!servo_on_cmd [*4];
	endsequence
	sequence recalc_taken;
		recalc_start && !recalc_rejected && active_mode_on;
	endsequence
	chk_servo_off_end: assert property (servo_dropped |-> !active_mode_on)
		else $error("mode kept after servo off");
	chk_recalc_end: assert property (recalc_taken |=> !active_mode_on)
		else $error("mode kept after recalc");
	chk_sysrst_restart: assert property (system_reset_req && active_mode_on |=>
		!active_mode_on && servo_restart) else $error("system reset mishandled");
	chk_ot_owns_stop: assert property (ot_stop_en |-> !internal_decel_en)
		else $error("ramp left on under overtravel");
	chk_decel_in_mode: assert property (internal_decel_en |-> active_mode_on)
		else $error("ramp outside mode");
	chk_sff_blocked: assert property (active_mode_on |-> !speed_ff_en)
		else $error("speed ff in mode");
	chk_tff_blocked: assert property (active_mode_on |-> !torque_ff_en)
		else $error("torque ff in mode");
	chk_util_excl: assert property (!(utility_running && active_mode_on))
		else $error("utility and mode together");
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside slot");
endmodule // asmi_monitor
bind asmi_top asmi_monitor asmi_monitor_i (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .servo_on_cmd(servo_on_cmd), .system_reset_req(system_reset_req),
	.recalc_start(recalc_start), .recalc_rejected(recalc_rejected),
	.active_mode_on(active_mode_on), .internal_decel_en(internal_decel_en),
	.ot_stop_en(ot_stop_en), .speed_ff_en(speed_ff_en), .torque_ff_en(torque_ff_en),
	.utility_running(utility_running), .servo_restart(servo_restart));
`default_nettype wire

// ---- asmi_sync.v ----
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module asmi_sync #(
	parameter WIDTH = 3
) (
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	genvar i;
	// one pair of flops per bit; the first stage feeds only the second
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta_reg;
			reg stable_reg;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_reg <= 1'b0;
					stable_reg <= 1'b0;
				end else if (ce) begin
					meta_reg <= async_in[i];
					stable_reg <= meta_reg;
				end
			end
			assign sync_out[i] = stable_reg;
		end
	endgenerate
endmodule // asmi_sync
`default_nettype wire

// ---- asmi_top.v ----
// active stop mode interlock: mode state machine, registers, path gating
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "asmi_defines.vh"
module asmi_top #(
	parameter TICK_CYCLES = `ASMI_TICK_NS / `ASMI_CLK_PERIOD_NS
) (
	input wire clk,
	input wire rst_n,
	input wire ce,
	// register port
	input wire [`ASMI_ADDR_W-1:0] reg_addr,
	input wire [`ASMI_DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output wire [`ASMI_DATA_W-1:0] reg_rdata,
	// pins, asynchronous
	input wire safety_request_on,
	input wire servo_on_cmd,
	input wire overtravel_in,
	// same-clock drive logic
	input wire motor_stopped,
	input wire system_reset_req,
	input wire recalc_start,
	input wire recalc_rejected,
	input wire utility_done,
	input wire [`ASMI_LVL_W-1:0] position_error_abs,
	input wire [`ASMI_LVL_W-1:0] speed_reference_abs,
	// outputs, all registered
	output wire active_mode_on,
	output wire internal_decel_en,
	output wire ot_stop_en,
	output wire [1:0] ot_stop_method,
	output wire zero_clamp_en,
	output wire speed_ff_en,
	output wire torque_ff_en,
	output wire utility_running,
	output wire servo_restart
);
	// idle: normal operation, the host reference drives the motor
	localparam ST_IDLE = `ASMI_ST_IDLE;
	// decel: the internal ramp brings the motor down
	localparam ST_DECEL = `ASMI_ST_DECEL;
	// otstop: overtravel handling owns the stop, the ramp is dropped
	localparam ST_OTSTOP = `ASMI_ST_OTSTOP;

	// synchronised pin levels; behind two flops the mode answers a pin
	// change at the third edge after it
	wire [2:0] pins_s;
	wire safety_on_s = pins_s[0];
	wire servo_on_s = pins_s[1];
	wire overtravel_s = pins_s[2];

	asmi_sync #(
		.WIDTH(3)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.async_in({overtravel_in, servo_on_cmd, safety_request_on}),
		.sync_out(pins_s)
	);

	// software registers
	reg [`ASMI_CTRL_W-1:0] ctrl_reg;
	reg [`ASMI_HOLD_W-1:0] hold_reg;
	reg [`ASMI_LVL_W-1:0] pos_lvl_reg;
	reg [`ASMI_LVL_W-1:0] spd_lvl_reg;
	reg entry_refused_reg;
	reg util_refused_reg;
	reg util_running_reg;
	reg [`ASMI_DATA_W-1:0] rdata_reg;

	// mode state
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg ot_stopped_reg;

	// registered outputs
	reg active_reg;
	reg decel_reg;
	reg ot_reg;
	reg [1:0] ot_method_reg;
	reg zc_reg;
	reg sff_reg;
	reg tff_reg;
	reg restart_reg;

	// decoded strobes
	wire wr_ctrl = reg_wr && (reg_addr == `ASMI_OFS_CTRL);
	wire wr_hold = reg_wr && (reg_addr == `ASMI_OFS_HOLD);
	wire wr_poslvl = reg_wr && (reg_addr == `ASMI_OFS_POSLVL);
	wire wr_spdlvl = reg_wr && (reg_addr == `ASMI_OFS_SPDLVL);
	wire wr_status = reg_wr && (reg_addr == `ASMI_OFS_STATUS);
	wire wr_util = reg_wr && (reg_addr == `ASMI_OFS_UTIL);
	wire util_start = wr_util && reg_wdata[`ASMI_UTIL_START];
	wire util_stop = wr_util && reg_wdata[`ASMI_UTIL_STOP];

	wire in_mode = (state_reg != ST_IDLE);
	wire active_next = (state_next != ST_IDLE);

	// hold timer restarts on entry, and after an overtravel takeover it only
	// starts once the motor has actually come to rest
	// a hold that ran out under the ramp does not count for the takeover
	wire hold_clear = (state_reg == ST_IDLE) ||
		((state_reg == ST_OTSTOP) && !ot_stopped_reg);
	wire hold_elapsed;

	asmi_hold_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_hold (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.clear(hold_clear),
		.hold_time(hold_reg),
		.elapsed(hold_elapsed)
	);

	// each magnitude against its own release level; a value equal to the
	// level still counts as within it
	wire pos_level_ok = (position_error_abs <= pos_lvl_reg);
	wire spd_level_ok = (speed_reference_abs <= spd_lvl_reg);

	// release level depends on control mode: position error or speed reference
	wire level_ok = ctrl_reg[`ASMI_CTRL_POS_MODE] ? pos_level_ok : spd_level_ok;
	wire release_ok = safety_on_s && hold_elapsed && level_ok;

	// entry wanted: safety request active (input off) with servo on
	// the request input is on while nothing is asked, so low means stop
	wire entry_req = !safety_on_s && servo_on_s;
	wire entry_block = util_running_reg || util_start;
	wire recalc_ends = recalc_start && !recalc_rejected;

	// next-state logic; termination causes take priority over everything else
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				// a reset in the same cycle wins over a fresh request
				if (entry_req && !entry_block && !system_reset_req)
					state_next = ST_DECEL;
			end
			ST_DECEL: begin
				// the ramp runs until a stop cause, overtravel or release
				if (system_reset_req)
					state_next = ST_IDLE;
				else if (!servo_on_s)
					state_next = ST_IDLE;
				else if (recalc_ends)
					state_next = ST_IDLE;
				else if (overtravel_s)
					state_next = ST_OTSTOP;
				else if (release_ok)
					state_next = ST_IDLE;
			end
			ST_OTSTOP: begin
				// overtravel may clear here; the mode still waits for rest and hold
				if (system_reset_req)
					state_next = ST_IDLE;
				else if (!servo_on_s)
					state_next = ST_IDLE;
				else if (recalc_ends)
					state_next = ST_IDLE;
				else if (ot_stopped_reg && release_ok)
					state_next = ST_IDLE;
			end
			default: begin
				// unused code: fall back to normal operation
				state_next = ST_IDLE;
			end
		endcase
	end

	// mode state and the motor-at-rest latch used during overtravel takeover
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			ot_stopped_reg <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			if (state_next != ST_OTSTOP)
				ot_stopped_reg <= 1'b0;
			else if ((state_reg == ST_OTSTOP) && motor_stopped)
				ot_stopped_reg <= 1'b1;
		end
	end

	// next values of the gated paths; the clamp is only withheld on the analog
	// and pulse-train variant, the feedforward paths on every variant
	wire zc_next = ctrl_reg[`ASMI_CTRL_ZC] &&
		!(active_next && ctrl_reg[`ASMI_CTRL_ANALOG]);
	wire sff_next = ctrl_reg[`ASMI_CTRL_SFF] && !active_next;
	wire tff_next = ctrl_reg[`ASMI_CTRL_TFF] && !active_next;
	// a restart is only asked for when the reset cuts a mode that is in force
	wire restart_next = system_reset_req && in_mode;

	// output paths follow the next state so status and gating move together
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_reg <= 1'b0;
			decel_reg <= 1'b0;
			ot_reg <= 1'b0;
			ot_method_reg <= 2'h0;
			zc_reg <= 1'b0;
			sff_reg <= 1'b0;
			tff_reg <= 1'b0;
			restart_reg <= 1'b0;
		end else if (ce) begin
			active_reg <= active_next;
			decel_reg <= (state_next == ST_DECEL);
			ot_reg <= (state_next == ST_OTSTOP);
			ot_method_reg <= ctrl_reg[`ASMI_CTRL_OT_MSB:`ASMI_CTRL_OT_LSB];
			zc_reg <= zc_next;
			sff_reg <= sff_next;
			tff_reg <= tff_next;
			restart_reg <= restart_next;
		end
	end

	// configuration registers written by software
	// a write lands at the edge of its strobe; the port never waits
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= `ASMI_CTRL_RST;
			hold_reg <= `ASMI_HOLD_RST;
			pos_lvl_reg <= `ASMI_POSLVL_RST;
			spd_lvl_reg <= `ASMI_SPDLVL_RST;
		end else if (ce) begin
			if (wr_ctrl)
				ctrl_reg <= reg_wdata[`ASMI_CTRL_W-1:0];
			if (wr_hold)
				hold_reg <= reg_wdata[`ASMI_HOLD_W-1:0];
			if (wr_poslvl)
				pos_lvl_reg <= reg_wdata[`ASMI_LVL_W-1:0];
			if (wr_spdlvl)
				spd_lvl_reg <= reg_wdata[`ASMI_LVL_W-1:0];
		end
	end

	// utility run flag; a start while the mode is in force is refused and
	// remembered, and a refusal set in the same cycle as a clear survives
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			util_running_reg <= 1'b0;
			util_refused_reg <= 1'b0;
			entry_refused_reg <= 1'b0;
		end else if (ce) begin
			if (util_start && (in_mode || active_next))
				util_refused_reg <= 1'b1;
			else if (wr_status && reg_wdata[`ASMI_STAT_UTIL_REF])
				util_refused_reg <= 1'b0;
			if (util_start && !in_mode && !active_next)
				util_running_reg <= 1'b1;
			else if (util_stop || utility_done)
				util_running_reg <= 1'b0;
			if ((state_reg == ST_IDLE) && entry_req && entry_block)
				entry_refused_reg <= 1'b1;
			else if (wr_status && reg_wdata[`ASMI_STAT_ENTRY_REF])
				entry_refused_reg <= 1'b0;
		end
	end

	// status word as seen by software
	// bits five and six stay set until software writes them back with a one
	wire [`ASMI_STAT_W-1:0] status_word;
	assign status_word[`ASMI_STAT_ACTIVE] = in_mode;
	assign status_word[`ASMI_STAT_DECEL] = (state_reg == ST_DECEL);
	assign status_word[`ASMI_STAT_OT] = (state_reg == ST_OTSTOP);
	assign status_word[`ASMI_STAT_HOLD_DONE] = hold_elapsed;
	assign status_word[`ASMI_STAT_UTIL] = util_running_reg;
	assign status_word[`ASMI_STAT_ENTRY_REF] = entry_refused_reg;
	assign status_word[`ASMI_STAT_UTIL_REF] = util_refused_reg;
	assign status_word[`ASMI_STAT_RELEASE_OK] = release_ok;

	// read data stand one cycle after the strobe and only then;
	// unmapped offsets read as zero
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h00000000;
		end else if (ce) begin
			rdata_reg <= 32'h00000000;
			if (reg_rd) begin
				case (reg_addr)
					`ASMI_OFS_CTRL: rdata_reg <= {25'h0000000, ctrl_reg};
					`ASMI_OFS_HOLD: rdata_reg <= {16'h0000, hold_reg};
					`ASMI_OFS_POSLVL: rdata_reg <= {16'h0000, pos_lvl_reg};
					`ASMI_OFS_SPDLVL: rdata_reg <= {16'h0000, spd_lvl_reg};
					`ASMI_OFS_STATUS: rdata_reg <= {24'h000000, status_word};
					`ASMI_OFS_UTIL: rdata_reg <= {31'h00000000, util_running_reg};
					default: rdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	// the host watches active_mode_on to halt and later resume its reference
	assign active_mode_on = active_reg;
	assign internal_decel_en = decel_reg;
	assign ot_stop_en = ot_reg;
	assign ot_stop_method = ot_method_reg;
	assign zero_clamp_en = zc_reg;
	assign speed_ff_en = sff_reg;
	assign torque_ff_en = tff_reg;
	assign utility_running = util_running_reg;
	assign servo_restart = restart_reg;
	assign reg_rdata = rdata_reg;
endmodule // asmi_top
`default_nettype wire

// ---- asmi_top_bench.sv ----
// self-checking testbench for the active stop mode interlock
`timescale 1ns/1ps
`default_nettype none
module asmi_top_bench;
	logic clk = 0, rst_n = 0, reg_rd = 0, reg_wr = 0, safety = 1, servo = 1, ot = 0;
	logic stopped = 0, sysr = 0, rc = 0, rrej = 0, udone = 0, stub = 0;
	logic [7:0] addr = 0;
	logic [6:0] ctrl;
	logic [31:0] wdata = 0, rdata, d;
	logic [15:0] perr = 0, ref_cmd = 0, ref_abs;
	wire act, dec, ots, zc, sff, tff, urun, rstp;
	wire [1:0] meth;
	logic [1:0] seen;
	integer error_cnt = 0, checks_done = 0, seed = 32'h6cc8999e;
	initial forever #12.5 clk = ~clk;
	asmi_top #(.TICK_CYCLES(4)) asmi_top_i (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
		.safety_request_on(safety), .servo_on_cmd(servo), .overtravel_in(ot),
		.motor_stopped(stopped), .system_reset_req(sysr), .recalc_start(rc),
		.recalc_rejected(rrej), .utility_done(udone), .position_error_abs(perr),
		.speed_reference_abs(ref_abs), .active_mode_on(act), .internal_decel_en(dec),
		.ot_stop_en(ots), .ot_stop_method(meth), .zero_clamp_en(zc), .speed_ff_en(sff),
		.torque_ff_en(tff), .utility_running(urun), .servo_restart(rstp));
	asmi_host_model asmi_host_model_i (.clk(clk), .rst_n(rst_n), .active_mode_on(act),
		.stubborn(stub), .ref_cmd(ref_cmd), .ref_abs(ref_abs));
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task results;
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// expected {tff, sff, zc} for a control word and mode state
	function logic [2:0] gates(input logic [6:0] c, input logic a);
		return {c[4] & !a, c[3] & !a, c[2] & !(a & c[1])};
	endfunction
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	// read data stand only in the cycle after the strobe
	task bus_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_rd <= 1;
		addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		@(negedge clk);
		v = rdata;
		@(posedge clk);
	endtask
	// w: 0 accepted recalc, 1 rejected recalc, 2 system reset
	task pulse(input int w);
		@(posedge clk);
		rc <= (w < 2);
		rrej <= (w == 1);
		sysr <= (w == 2);
		@(posedge clk);
		rc <= 0;
		rrej <= 0;
		sysr <= 0;
		// restart pulse and mode are looked at mid-cycle, where both are settled
		@(negedge clk);
		seen = {rstp, act};
		@(posedge clk);
	endtask
	task enter;
		safety <= 0;
		cyc(5);
	endtask
	task leave;
		safety <= 1;
		cyc(40);
		chk(act, 0);
	endtask
	initial begin
		cyc(20000);
		error_cnt++;
		results;
	end
	initial begin
		cyc(5);
		rst_n <= 1;
		bus_rd(8'h00, d); chk(d, 32'h1c);
		bus_rd(8'h04, d); chk(d, 32'h64);
		bus_rd(8'h08, d); chk(d, 32'h100);
		bus_rd(8'h0c, d); chk(d, 32'h100);
		bus_rd(8'h40, d); chk(d, 32'h0);
		ctrl = 7'h5e;
		bus_wr(8'h00, {25'h0, ctrl});
		bus_wr(8'h04, 32'h5);
		ref_cmd <= 16'h0101 + ($random(seed) & 16'h7ff);
		stub <= 1;
		enter;
		chk(dec, 1);
		chk({tff, sff, zc}, gates(ctrl, 1));
		safety <= 1;
		cyc(6);
		chk(act, 1);
		cyc(40);
		chk(act, 1);
		stub <= 0;
		cyc(5);
		chk(act, 0);
		chk({tff, sff, zc}, gates(ctrl, 0));
		enter;
		servo <= 0;
		cyc(5);
		chk(act, 0);
		servo <= 1;
		leave;
		enter;
		pulse(1);
		chk(seen[0], 1);
		// safety back on first, so the pin does not re-enter after the recalc
		safety <= 1;
		pulse(0);
		chk(seen[0], 0);
		chk(act, 0);
		leave;
		enter;
		pulse(2);
		chk(seen, 2'b10);
		leave;
		enter;
		ot <= 1;
		cyc(5);
		chk({ots, dec, meth}, {2'b10, ctrl[6:5]});
		safety <= 1;
		cyc(40);
		chk(act, 1);
		stopped <= 1;
		ot <= 0;
		cyc(8);
		chk(act, 1);
		cyc(32);
		chk(act, 0);
		stopped <= 0;
		enter;
		bus_wr(8'h14, 32'h1);
		bus_rd(8'h10, d);
		chk({d[6], urun}, 2'b10);
		leave;
		bus_wr(8'h14, 32'h1);
		enter;
		chk({urun, act}, 2'b10);
		bus_rd(8'h10, d);
		chk(d[5], 1);
		// safety is back on through the flops before the utility ends
		safety <= 1;
		cyc(2);
		udone <= 1;
		cyc(1);
		udone <= 0;
		cyc(3);
		chk({urun, act}, 2'b00);
		// random control words, both control modes
		for (int i = 0; i < 4; i++) begin
			ctrl = $random(seed);
			ctrl[0] = i[0];
			perr <= $random(seed) & 16'hff;
			bus_wr(8'h00, {25'h0, ctrl});
			enter;
			chk({tff, sff, zc}, gates(ctrl, 1));
			leave;
			chk({tff, sff, zc}, gates(ctrl, 0));
		end
		results;
	end
endmodule // asmi_top_bench
`default_nettype wire
